/* File: tb_tpsp_two_port_sram.sv */
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the memory block
module tb_tpsp_two_port_sram;
  reg clk_sys_in = 1'b0, rst_n_in = 1'b0, wb_we_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
  reg [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'h0;
  reg [31:0] wb_dat_in = 32'h0000_0000, rd;
  wire wb_ack_out, wclk, rclk, rsel_n, rstb_n, wsel_n, wstb_n, rpf, wpf;
  wire [31:0] wb_dat_out;
  wire [7:0] read_addr, write_addr;
  wire [8:0] wword, rword;
  integer bad_count = 0, tests_run = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  tpsp_two_port_sram DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .write_side_clock_in(wclk),
    .read_side_clock_in(rclk), .read_addr_in(read_addr), .write_addr_in(write_addr),
    .read_select_n_in(rsel_n), .read_strobe_n_in(rstb_n), .write_select_n_in(wsel_n),
    .write_strobe_n_in(wstb_n), .write_word_in(wword), .read_word_out(rword),
    .read_parity_fault_out(rpf), .write_parity_fault_out(wpf), .wb_adr_in(wb_adr_in),
    .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in), .wb_we_in(wb_we_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
  tpsp_fabric_user usr (.clk_sys_in(clk_sys_in), .write_side_clock_out(wclk),
    .read_side_clock_out(rclk), .read_addr_out(read_addr), .write_addr_out(write_addr),
    .read_select_n_out(rsel_n), .read_strobe_n_out(rstb_n), .write_select_n_out(wsel_n),
    .write_strobe_n_out(wstb_n), .write_word_out(wword));
  task check(input [31:0] seen, input [31:0] want);
    begin
      tests_run = tests_run + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // one classic bus cycle, held until ack is sampled
  task wb(input we, input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys_in);
      {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in, wb_sel_in} <= {2'h3, we, a, d, 4'hf};
      n = 0;
      do begin
        @(posedge clk_sys_in);
        n = n + 1;
      end while (wb_ack_out !== 1'b1 && n < 50);
      if (n >= 50) begin
        check(32'h0000_0000, 32'h0000_0001);
        give_verdict;
      end
      rd = wb_dat_out;
      {wb_cyc_in, wb_stb_in, wb_we_in, wb_sel_in} <= 7'h00;
    end
  endtask
  task t_reset;
    begin
      wb(1'b0, 4'h0, 0); check(rd, 32'h0000_0000);
      wb(1'b1, 4'h8, 32'hffff_ffff); wb(1'b0, 4'h8, 0); check(rd, 32'h0000_0000);
      $display("reset and bus test done");
    end
  endtask
  task t_plain;
    begin
      usr.access(1, 1, 8'h10, 9'h003); check(wpf, 0);
      usr.access(1, 1, 8'h11, 9'h001); check(wpf, 1);
      usr.access(1, 0, 8'h10, 9'h0ff); usr.access(0, 1, 8'h10, 0); check(rword, 9'h003);
      usr.access(0, 1, 8'h11, 0); check({rpf, rword}, 10'h201);
      usr.access(0, 0, 8'h10, 0); check(rword, 9'h001);
      wb(1'b0, 4'h4, 0); check(rd, 32'h0000_0303);
      $display("transparent test done");
    end
  endtask
  task t_gen;
    begin
      wb(1'b1, 4'h0, 32'h0000_0003); usr.access(1, 1, 8'h20, 9'h000); check(wpf, 0);
      wb(1'b1, 4'h0, 32'h0000_0001); usr.access(1, 1, 8'h21, 9'h100);
      usr.access(0, 1, 8'h21, 0); check({rpf, rword}, 10'h000);
      wb(1'b1, 4'h0, 32'h0000_0002); usr.access(0, 1, 8'h21, 0); check(rpf, 1);
      usr.access(0, 1, 8'h20, 0); check({rpf, rword}, 10'h100);
      $display("parity test done");
    end
  endtask
  task t_pipe;
    begin
      wb(1'b1, 4'h0, 32'h0000_0004); usr.access(0, 1, 8'h10, 0); check(rword, 9'h000);
      usr.access(0, 0, 8'h00, 0); check(rword, 9'h003);
      $display("pipelined test done");
    end
  endtask
  task t_async;
    begin
      wb(1'b1, 4'h0, 32'h0000_0008); usr.hold_read(8'h11);
      repeat (8) @(posedge clk_sys_in);
      check(rword, 9'h001);
      usr.hold_read(8'h20);
      repeat (8) @(posedge clk_sys_in);
      check(rword, 9'h100);
      $display("address read test done");
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_reset;
    t_plain;
    t_gen;
    t_pipe;
    t_async;
    give_verdict;
  end
endmodule

/* File: tpsp_defs.vh */
`ifndef TPSP_DEFS_VH
`define TPSP_DEFS_VH
// ==========================================
// register byte offsets
`define TPSP_OFS_CTRL 4'h0
`define TPSP_OFS_STATUS 4'h4
// ==========================================
// control field positions
`define TPSP_CTRL_GEN_BIT 0
`define TPSP_CTRL_ODD_BIT 1
`define TPSP_CTRL_MODE_LO 2
`define TPSP_CTRL_MODE_HI 3
// ==========================================
// status field positions
`define TPSP_STAT_RD_LIVE_BIT 0
`define TPSP_STAT_WR_LIVE_BIT 1
`define TPSP_STAT_RD_STICKY_BIT 8
`define TPSP_STAT_WR_STICKY_BIT 9
// ==========================================
// read modes
`define TPSP_MODE_TRANSPARENT 2'h0
`define TPSP_MODE_PIPELINED 2'h1
`define TPSP_MODE_ASYNC 2'h2
// ==========================================
// reset values
`define TPSP_CTRL_RESET 4'h0
`define TPSP_WORD_RESET 9'h000
`define TPSP_BUS_RESET 32'h0000_0000
// ==========================================
// sizes
`define TPSP_ADDR_W 8
`define TPSP_WORD_W 9
`define TPSP_DEPTH 256
`define TPSP_PIN_W 31
`endif

/* File: tpsp_fabric_user.sv */
`timescale 1ns/1ps
// ==========================================
// fabric user logic driving the memory pins
module tpsp_fabric_user (
  input wire clk_sys_in,
  output reg write_side_clock_out = 1'b0,
  output reg read_side_clock_out = 1'b0,
  output reg [7:0] read_addr_out = 8'h00,
  output reg [7:0] write_addr_out = 8'h00,
  output reg read_select_n_out = 1'b1,
  output reg read_strobe_n_out = 1'b1,
  output reg write_select_n_out = 1'b1,
  output reg write_strobe_n_out = 1'b1,
  output reg [8:0] write_word_out = 9'h000
);
  // one access: lines held ten cycles around a single clock rise
  // one side per call, so no location is read and written at once
  task access(input wr, input on, input [7:0] a, input [8:0] d);
    integer i;
    begin
      @(posedge clk_sys_in);
      if (wr) {write_addr_out, write_word_out, write_select_n_out, write_strobe_n_out} <= {a, d, !on, !on};
      else {read_addr_out, read_select_n_out, read_strobe_n_out} <= {a, !on, !on};
      for (i = 0; i < 10; i = i + 1) begin
        @(posedge clk_sys_in);
        if (wr) write_side_clock_out <= (i >= 2 && i < 6);
        else read_side_clock_out <= (i >= 2 && i < 6);
      end
      // released lines show the inverse, controls go idle
      if (wr) {write_addr_out, write_word_out, write_select_n_out, write_strobe_n_out} <= {~a, ~d, 2'h3};
      else {read_addr_out, read_select_n_out, read_strobe_n_out} <= {~a, 2'h3};
    end
  endtask
  // strobe low with a new address and no clock, for the address-driven read
  task hold_read(input [7:0] a);
    begin
      @(posedge clk_sys_in);
      {read_addr_out, read_strobe_n_out} <= {a, 1'b0};
    end
  endtask
endmodule

/* File: tpsp_props.sv */
`timescale 1ns/1ps
// ==========================================
// port checks for the memory block
module tpsp_props (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire write_side_clock_in,
  input wire write_select_n_in,
  input wire write_strobe_n_in,
  input wire write_parity_fault_out,
  input wire [3:0] wb_adr_in,
  input wire wb_we_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire [31:0] wb_dat_out,
  input wire wb_ack_out
);
  reg wclk_q = 1'b0;
  reg [3:0] wr_age = 4'hf;
  wire req = wb_cyc_in && wb_stb_in;
  wire rd_ack = wb_ack_out && !wb_we_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // cycles since the last taken write clock rise
  always @(posedge clk_sys_in) begin
    wclk_q <= write_side_clock_in;
    if (write_side_clock_in && !wclk_q && !write_select_n_in && !write_strobe_n_in) begin
      wr_age <= 4'h0;
    end else if (wr_age != 4'hf) begin
      wr_age <= wr_age + 4'h1;
    end
  end
  a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  a_ack_follows_req: assert property (req && !wb_ack_out |=> wb_ack_out) else $error("no ack");
  a_ack_has_cause: assert property (wb_ack_out |-> $past(req)) else $error("ack without request");
  a_rdata_holds: assert property (!$stable(wb_dat_out) |-> rd_ack) else $error("read data moved");
  a_unmapped_zero: assert property (rd_ack && wb_adr_in != 4'h0 && wb_adr_in != 4'h4
    |-> wb_dat_out == 32'h0000_0000) else $error("unmapped read not zero");
  a_ctrl_narrow: assert property (rd_ack && wb_adr_in == 4'h0
    |-> wb_dat_out[31:4] == 28'h000_0000) else $error("control upper bits set");
  a_wfault_cause: assert property (!$stable(write_parity_fault_out) |-> wr_age inside {[1:7]})
    else $error("write fault moved without a write");
  a_reset_quiet: assert property ($rose(rst_n_in) |-> !wb_ack_out && !write_parity_fault_out)
    else $error("outputs busy after reset");
  c_bus_write: cover property (req && wb_we_in);
  c_bus_read: cover property (req && !wb_we_in);
  c_wfault: cover property ($rose(write_parity_fault_out));
endmodule
bind tpsp_two_port_sram tpsp_props u_props (.clk_sys_in, .rst_n_in, .write_side_clock_in,
  .write_select_n_in, .write_strobe_n_in, .write_parity_fault_out, .wb_adr_in, .wb_we_in,
  .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out);

/* File: tpsp_two_port_sram.v */
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - write side follows its own write clock, read side its own read clock
// - nine data bits in; with generation on, bit 8 is computed here
// - sense bit picks odd when high, even when low; two fault outputs
// - nine data bits out carry the word at the read address
// - transparent mode: outputs change in the same read clock cycle
// - pipelined mode: outputs update after the second read clock rise
// - async mode: strobe low, output follows read address with no clock edge
`include "tpsp_defs.vh"

module tpsp_two_port_sram (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire write_side_clock_in,
  input wire read_side_clock_in,
  input wire [7:0] read_addr_in,
  input wire [7:0] write_addr_in,
  input wire read_select_n_in,
  input wire read_strobe_n_in,
  input wire write_select_n_in,
  input wire write_strobe_n_in,
  input wire [8:0] write_word_in,
  output reg [8:0] read_word_out,
  output reg read_parity_fault_out,
  output reg write_parity_fault_out,
  input wire [3:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire [3:0] wb_sel_in,
  input wire wb_we_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out
);

  // ==========================================
  // helpers
  // parity bit that makes the nine bits meet the sense
  function gen_par;
    input [7:0] data;
    input odd;
    begin
      gen_par = (^data) ^ odd;
    end
  endfunction

  // high when the nine bits miss the sense
  function par_fault;
    input [8:0] word;
    input odd;
    begin
      par_fault = (^word) ^ odd;
    end
  endfunction

  // ==========================================
  // reset release
  reg rst_meta_n;
  reg rst_sync_n;

  // two stage release of the external reset
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================
  // pin synchronisers
  wire [`TPSP_PIN_W-1:0] pin_raw;
  reg [`TPSP_PIN_W-1:0] pin_meta;
  reg [`TPSP_PIN_W-1:0] pin_sync;
  reg wclk_last;
  reg rclk_last;

  assign pin_raw = {write_side_clock_in, read_side_clock_in, read_addr_in, write_addr_in,
                    read_select_n_in, read_strobe_n_in, write_select_n_in,
                    write_strobe_n_in, write_word_in};

  // two flops on every pin, then clock history
  always @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= {`TPSP_PIN_W{1'b1}};
      pin_sync <= {`TPSP_PIN_W{1'b1}};
      wclk_last <= 1'b1;
      rclk_last <= 1'b1;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      wclk_last <= pin_sync[30];
      rclk_last <= pin_sync[29];
    end
  end

  wire wclk_s = pin_sync[30];
  wire rclk_s = pin_sync[29];
  // pin map after the synchroniser, msb first:
  // 30 write clock, 29 read clock, 28:21 read address,
  // 20:13 write address, 12 read select, 11 read strobe,
  // 10 write select, 9 write strobe, 8:0 write word
  wire [7:0] read_addr_s = pin_sync[28:21];
  wire [7:0] write_addr_s = pin_sync[20:13];
  wire rsel_n_s = pin_sync[12];
  wire rstb_n_s = pin_sync[11];
  wire wsel_n_s = pin_sync[10];
  wire wstb_n_s = pin_sync[9];
  wire [8:0] wword_s = pin_sync[8:0];

  // rising edges of each side clock
  wire wclk_rise = wclk_s & ~wclk_last;
  wire rclk_rise = rclk_s & ~rclk_last;

  // ==========================================
  // control register
  reg [3:0] ctrl;
  reg rd_sticky;
  reg wr_sticky;
  wire gen_en = ctrl[`TPSP_CTRL_GEN_BIT];
  wire sense_odd = ctrl[`TPSP_CTRL_ODD_BIT];
  wire [1:0] mode = ctrl[`TPSP_CTRL_MODE_HI:`TPSP_CTRL_MODE_LO];
  // mode code 3 is unused and falls back to transparent reads
  // a control change applies from the next detected pin clock rise, in async mode from the next cycle with strobe low
  // memory words are not cleared by reset

  // ==========================================
  // write side
  reg [8:0] mem [0:`TPSP_DEPTH-1];
  wire write_go = wclk_rise & ~wsel_n_s & ~wstb_n_s;
  wire [8:0] stored_word;

  // generated bit replaces input bit 8
  assign stored_word = gen_en ? {gen_par(wword_s[7:0], sense_odd), wword_s[7:0]} :
                       wword_s;

  // storage array, no reset
  always @(posedge clk_sys_in) begin
    if (write_go) begin
      mem[write_addr_s] <= stored_word;
    end
  end

  // write fault checks the nine bits written
  reg next_write_fault;

  // fault value for the word about to be stored, held between writes
  always @* begin
    next_write_fault = write_parity_fault_out;
    if (write_go) begin
      next_write_fault = par_fault(stored_word, sense_odd);
    end
  end

  // write fault register
  always @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      write_parity_fault_out <= 1'b0;
    end else begin
      write_parity_fault_out <= next_write_fault;
    end
  end

  // ==========================================
  // read side
  // same-address collisions are left to the user
  wire read_go = rclk_rise & ~rsel_n_s & ~rstb_n_s;
  wire [8:0] mem_word = mem[read_addr_s];
  wire mem_fault = par_fault(mem_word, sense_odd);
  reg [8:0] pipe_word;
  reg pipe_fault;

  // ==========================================
  // read side next values
  reg [8:0] next_read_word;
  reg next_read_fault;
  reg [8:0] next_pipe_word;
  reg next_pipe_fault;

  // pick what outputs and pipeline stage take next, per read mode
  always @* begin
    next_read_word = read_word_out;
    next_read_fault = read_parity_fault_out;
    next_pipe_word = pipe_word;
    next_pipe_fault = pipe_fault;
    case (mode)
      `TPSP_MODE_PIPELINED: begin
        // stage moves out on any read clock rise, loads only on an access
        if (rclk_rise) begin
          next_read_word = pipe_word;
          next_read_fault = pipe_fault;
        end
        if (read_go) begin
          next_pipe_word = mem_word;
          next_pipe_fault = mem_fault;
        end
      end
      `TPSP_MODE_ASYNC: begin
        // strobe alone opens the path, output tracks the address
        if (!rstb_n_s) begin
          next_read_word = mem_word;
          next_read_fault = mem_fault;
        end
      end
      `TPSP_MODE_TRANSPARENT: begin
        // word shows one cycle after the detected read clock rise
        if (read_go) begin
          next_read_word = mem_word;
          next_read_fault = mem_fault;
        end
      end
      default: begin
        // unused mode code behaves as transparent
        if (read_go) begin
          next_read_word = mem_word;
          next_read_fault = mem_fault;
        end
      end
    endcase
  end

  // output and pipeline registers
  always @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pipe_word <= `TPSP_WORD_RESET;
      pipe_fault <= 1'b0;
      read_word_out <= `TPSP_WORD_RESET;
      read_parity_fault_out <= 1'b0;
    end else begin
      pipe_word <= next_pipe_word;
      pipe_fault <= next_pipe_fault;
      read_word_out <= next_read_word;
      read_parity_fault_out <= next_read_fault;
    end
  end

  // ==========================================
  // wishbone slave
  wire bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire bus_wr = bus_req & wb_we_in;
  wire hit_ctrl = (wb_adr_in == `TPSP_OFS_CTRL);
  wire hit_stat = (wb_adr_in == `TPSP_OFS_STATUS);
  wire clr_rd = bus_wr & hit_stat & wb_sel_in[1] & wb_dat_in[`TPSP_STAT_RD_STICKY_BIT];
  wire clr_wr = bus_wr & hit_stat & wb_sel_in[1] & wb_dat_in[`TPSP_STAT_WR_STICKY_BIT];
  reg [31:0] next_rdata;

  // read mux, unmapped reads zero
  // status shows live faults low and sticky faults in the second byte
  always @* begin
    next_rdata = `TPSP_BUS_RESET;
    if (hit_ctrl) begin
      next_rdata[3:0] = ctrl;
    end else if (hit_stat) begin
      next_rdata[`TPSP_STAT_RD_LIVE_BIT] = read_parity_fault_out;
      next_rdata[`TPSP_STAT_WR_LIVE_BIT] = write_parity_fault_out;
      next_rdata[`TPSP_STAT_RD_STICKY_BIT] = rd_sticky;
      next_rdata[`TPSP_STAT_WR_STICKY_BIT] = wr_sticky;
    end
  end

  // ack one cycle after the request, read data taken with it
  always @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= `TPSP_BUS_RESET;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_req && !wb_we_in) begin
        wb_dat_out <= next_rdata;
      end
    end
  end

  // control register, low byte lane only
  always @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl <= `TPSP_CTRL_RESET;
    end else if (bus_wr && hit_ctrl && wb_sel_in[0]) begin
      ctrl <= wb_dat_in[3:0];
    end
  end

  // sticky faults, a new fault beats a clear in the same cycle
  always @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_sticky <= 1'b0;
      wr_sticky <= 1'b0;
    end else begin
      rd_sticky <= read_parity_fault_out | (rd_sticky & ~clr_rd);
      wr_sticky <= write_parity_fault_out | (wr_sticky & ~clr_wr);
    end
  end

endmodule
